// file: shared/led_ctrl_pkg.sv
// ----------------------------------------
// Serial LED display controller constants
// ----------------------------------------
package led_ctrl_pkg;

    // ----------------------------------------
    // Frame layout
    // ----------------------------------------
    localparam int FRAME_BITS = 16;      // Bits per programming frame
    localparam int DIGITS = 8;           // Digit registers in the memory
    localparam int FRAME_MSB = 15;       // First bit on the wire

    // Frame as it sits in the shift register
    typedef struct packed {
        logic [3:0] ignored;             // Don't-care upper nibble
        logic [3:0] addr;                // Register address
        logic [7:0] data;                // Register data
    } frame_t;

    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [3:0] ADDR_NOP = 4'h0;
    localparam logic [3:0] ADDR_DIGIT0 = 4'h1;
    localparam logic [3:0] ADDR_DIGIT7 = 4'h8;
    localparam logic [3:0] ADDR_DECODE = 4'h9;
    localparam logic [3:0] ADDR_INTENSITY = 4'hA;
    localparam logic [3:0] ADDR_SCAN_LIMIT = 4'hB;
    localparam logic [3:0] ADDR_SHUTDOWN_CONTROL = 4'hC;
    localparam logic [3:0] ADDR_UNUSED = 4'hD;
    localparam logic [3:0] ADDR_RESET_CLOCK = 4'hE;
    localparam logic [3:0] ADDR_TEST = 4'hF;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int NORMAL_BIT = 0;       // Shutdown control: 1 = normal
    localparam int TEST_BIT = 0;         // Display test enable
    localparam int EXT_CLK_BIT = 0;      // External scan clock select
    localparam int SOFT_RESET_BIT = 1;   // Software reset request

    // ----------------------------------------
    // Reset values and display patterns
    // ----------------------------------------
    localparam logic [7:0] RST_DIGIT = 8'h00;
    localparam logic [7:0] RST_DECODE = 8'h00;
    localparam logic [3:0] RST_INTENSITY = 4'h0;
    localparam logic [2:0] RST_SCAN_LIMIT = 3'h0;
    localparam logic [7:0] SEG_ALL_ON = 8'hFF;
    localparam logic [7:0] SEG_ALL_OFF = 8'h00;
    localparam logic [7:0] DIG_ALL_OFF = 8'hFF;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CORE_CLK_HZ = 250_000_000;
    localparam int WAKE_TIME_US = 250;   // Shutdown exit time
    localparam int WAKE_CYCLES = WAKE_TIME_US * (CORE_CLK_HZ / 1_000_000);
    localparam int SCAN_RATE_HZ = 800;   // Full display refresh rate
    localparam int SCAN_CYCLES = CORE_CLK_HZ / (SCAN_RATE_HZ * DIGITS);

    // Power sequencing states
    typedef enum logic [2:0] {
        PWR_SHUTDOWN = 3'b001,
        PWR_WAKING = 3'b010,
        PWR_ON = 3'b100
    } pwr_state_t;

endpackage : led_ctrl_pkg

// file: verilog/pin_sync.sv
`timescale 1ns/100ps
// ----------------------------------------
// Two-flop synchroniser for one pin
// ----------------------------------------
module pin_sync (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic pin_in,
    output logic pin_sync_out
);
    logic meta_reg; // First stage, read only by the second

    // Both stages clear on reset to a known idle low
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta_reg <= 1'b0;
            pin_sync_out <= 1'b0;
        end else begin
            meta_reg <= pin_in;
            pin_sync_out <= meta_reg;
        end
    end
endmodule : pin_sync

// file: verilog/led_display_ctrl.sv
`timescale 1ns/100ps
// Operation
// R1 - Sixteen bits, MSB first, on shift rise
// R2 - Upper nibble ignored, address, then data
// R3 - Latch rise commits frame to addressed register
// R4 - Host raises latch before next shift rise
// R5 - Cascade output 16.5 cycles late, falling edge
// R6 - Fifteen registers selected by address nibble
// R7 - Eight digit bytes, written individually
// R8 - Decode, intensity, scan, shutdown, test, reset/clock
// R9 - Shutdown blanks segments and digits
// R10 - Digit contents kept during shutdown
// R11 - Shutdown exit takes 250 microseconds
// R12 - Writes accepted while shut down
// R13 - Only display test overrides shutdown
// R14 - Power-up resets registers, starts shut down
// R15 - Defaults: one digit, no decode, minimums
// R16 - Host may flash via repeated shutdown writes
// R17 - Address map of digits and controls
// R18 - Shutdown data bit zero selects mode
// R19 - Decode bit per digit selects decoder
// R20 - No-op and unused frames change nothing
module led_display_ctrl
    import led_ctrl_pkg::*;
#(
    parameter int WAKE_COUNT = WAKE_CYCLES,   // Shortened in simulation
    parameter int SCAN_COUNT = SCAN_CYCLES    // Shortened in simulation
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ser_din,
    input wire logic ser_clk,
    input wire logic ser_load,
    output logic ser_dout,
    output logic [7:0] seg_out,
    output logic [7:0] digit_off,
    output logic decode_now,
    output logic [3:0] intensity,
    output logic ext_clk_sel,
    output logic display_on
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic din_s, clk_s, load_s;   // Synchronised pins
    logic clk_d_reg, load_d_reg;  // Previous synchronised levels

    pin_sync u_sync_din (.core_clk(core_clk), .sys_rst(sys_rst), .pin_in(ser_din), .pin_sync_out(din_s));
    pin_sync u_sync_clk (.core_clk(core_clk), .sys_rst(sys_rst), .pin_in(ser_clk), .pin_sync_out(clk_s));
    pin_sync u_sync_load (.core_clk(core_clk), .sys_rst(sys_rst), .pin_in(ser_load), .pin_sync_out(load_s));

    wire clk_rise = clk_s & ~clk_d_reg;
    wire clk_fall = ~clk_s & clk_d_reg;
    wire load_rise = load_s & ~load_d_reg;

    // Edge history
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clk_d_reg <= 1'b0;
            load_d_reg <= 1'b0;
        end else begin
            clk_d_reg <= clk_s;
            load_d_reg <= load_s;
        end
    end

    // ----------------------------------------
    // Shift register and cascade output
    // ----------------------------------------
    frame_t shift_reg;            // Incoming frame
    logic cascade_reg;            // Extra whole stage toward the 16.5 delay
    logic dout_reg;

    // Shift on each link rise; the extra stage adds the last whole cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            shift_reg <= '0;
            cascade_reg <= 1'b0;
        end else if (clk_rise) begin
            shift_reg <= {shift_reg[FRAME_MSB-1:0], din_s}; // R1
            cascade_reg <= shift_reg[FRAME_MSB];            // R5
        end
    end

    // Cascade pin only moves on falling link edges
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dout_reg <= 1'b0;
        end else if (clk_fall) begin
            dout_reg <= cascade_reg; // R5
        end
    end
    assign ser_dout = dout_reg;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Upper nibble is never looked at
    wire [3:0] frm_addr = shift_reg.addr;                     // R2
    wire [7:0] frm_data = shift_reg.data;                     // R2
    wire hit_digit = (frm_addr >= ADDR_DIGIT0) && (frm_addr <= ADDR_DIGIT7); // R6 R17
    wire [2:0] digit_sel = 3'(frm_addr - ADDR_DIGIT0);
    wire wr_digit = load_rise & hit_digit;                    // R3
    wire wr_decode = load_rise & (frm_addr == ADDR_DECODE);
    wire wr_intensity = load_rise & (frm_addr == ADDR_INTENSITY);
    wire wr_scan = load_rise & (frm_addr == ADDR_SCAN_LIMIT);
    wire wr_shutdown = load_rise & (frm_addr == ADDR_SHUTDOWN_CONTROL);
    wire wr_reset_clk = load_rise & (frm_addr == ADDR_RESET_CLOCK);
    wire wr_test = load_rise & (frm_addr == ADDR_TEST);
    // Software reset acts like power-up on the register file (all but clock select) and power state only
    wire soft_rst = wr_reset_clk & frm_data[SOFT_RESET_BIT];
    wire regs_rst = sys_rst | soft_rst;                       // R14

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [7:0] digit_mem [DIGITS];   // 64 bits of digit storage
    logic [7:0] decode_reg;
    logic [3:0] intensity_reg;
    logic [2:0] scan_limit_reg;
    logic normal_reg;                 // 0 = shutdown requested
    logic test_reg;
    logic ext_clk_reg;

    // One byte per write; the others hold, shutdown or not
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < DIGITS; i++) begin
            if (regs_rst) begin
                digit_mem[i] <= RST_DIGIT;                    // R15
            end else if (wr_digit && digit_sel == 3'(i)) begin
                digit_mem[i] <= frm_data;                     // R7 R10 R12
            end
        end
    end

    // Control registers; no-op and unused addresses fall through
    always_ff @(posedge core_clk) begin
        if (regs_rst) begin
            decode_reg <= RST_DECODE;                         // R15
            intensity_reg <= RST_INTENSITY;                   // R15
            scan_limit_reg <= RST_SCAN_LIMIT;                 // R15
            normal_reg <= 1'b0;                               // R14
            test_reg <= 1'b0;
        end else begin
            if (wr_decode) decode_reg <= frm_data;            // R19
            if (wr_intensity) intensity_reg <= frm_data[3:0];
            if (wr_scan) scan_limit_reg <= frm_data[2:0];
            if (wr_shutdown) normal_reg <= frm_data[NORMAL_BIT]; // R18
            if (wr_test) test_reg <= frm_data[TEST_BIT];      // R8
        end
    end

    // Software reset leaves clock select alone; the reset frame's own bit 0 still loads it
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ext_clk_reg <= 1'b0;
        end else if (wr_reset_clk) begin
            ext_clk_reg <= frm_data[EXT_CLK_BIT];             // R8
        end
    end

    // ----------------------------------------
    // Shutdown sequencing
    // ----------------------------------------
    pwr_state_t pwr_reg, pwr_next;
    logic [31:0] wake_cnt_reg;

    // Exit waits out the oscillator restart time
    always_comb begin
        case (pwr_reg)
            PWR_SHUTDOWN: pwr_next = normal_reg ? PWR_WAKING : PWR_SHUTDOWN;
            PWR_WAKING: begin
                if (!normal_reg) pwr_next = PWR_SHUTDOWN;
                else if (wake_cnt_reg == 32'(WAKE_COUNT - 1)) pwr_next = PWR_ON; // R11
                else pwr_next = PWR_WAKING;
            end
            PWR_ON: pwr_next = normal_reg ? PWR_ON : PWR_SHUTDOWN; // R9 R16
            default: pwr_next = PWR_SHUTDOWN;
        endcase
    end

    // State and wake counter
    always_ff @(posedge core_clk) begin
        if (regs_rst) begin
            pwr_reg <= PWR_SHUTDOWN;                          // R14
            wake_cnt_reg <= '0;
        end else begin
            pwr_reg <= pwr_next;
            wake_cnt_reg <= (pwr_reg == PWR_WAKING) ? wake_cnt_reg + 32'h1 : '0;
        end
    end

    // ----------------------------------------
    // Digit scan and drivers
    // ----------------------------------------
    logic [31:0] scan_cnt_reg;
    logic [2:0] scan_idx_reg;
    logic [7:0] seg_reg, dig_reg;
    logic dec_reg;
    wire drive = (pwr_reg == PWR_ON) | test_reg;              // R13
    // Test lights all eight digits regardless of the limit
    wire [2:0] last_digit = test_reg ? 3'(DIGITS - 1) : scan_limit_reg;
    wire scan_tick = (scan_cnt_reg == 32'(SCAN_COUNT - 1));
    wire [7:0] dig_onehot = 8'h01 << scan_idx_reg;

    // Digit step timer; no intensity PWM here
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scan_cnt_reg <= '0;
            scan_idx_reg <= 3'h0;
        end else begin
            scan_cnt_reg <= scan_tick ? '0 : scan_cnt_reg + 32'h1;
            if (scan_tick) scan_idx_reg <= (scan_idx_reg >= last_digit) ? 3'h0 : scan_idx_reg + 3'h1;
        end
    end

    // Output drivers; shutdown blanks unless the test is on
    always_ff @(posedge core_clk) begin
        if (sys_rst || !drive) begin
            seg_reg <= SEG_ALL_OFF;                           // R9
            dig_reg <= DIG_ALL_OFF;                           // R9
            dec_reg <= 1'b0;
        end else begin
            seg_reg <= test_reg ? SEG_ALL_ON : digit_mem[scan_idx_reg]; // R13
            dig_reg <= ~dig_onehot;
            dec_reg <= ~test_reg & decode_reg[scan_idx_reg]; // R19
        end
    end

    assign seg_out = seg_reg;
    assign digit_off = dig_reg;
    assign decode_now = dec_reg;
    assign intensity = intensity_reg;
    assign ext_clk_sel = ext_clk_reg;
    assign display_on = (pwr_reg == PWR_ON);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_shift_capture: assert property (clk_rise |=> shift_reg == {$past(shift_reg[FRAME_MSB-1:0]), $past(din_s)}) // R1
        else $error("shift register missed a bit");
    a_dout_fall_only: assert property ($changed(dout_reg) |-> $past(clk_fall)) // R5
        else $error("cascade output moved off a falling edge");
    a_digit_write: assert property (wr_digit && !soft_rst |=> digit_mem[$past(digit_sel)] == $past(frm_data)) // R3
        else $error("digit write lost");
    a_digit_hold: assert property (!load_rise |=> $stable(digit_mem[0]) && $stable(digit_mem[7])) // R10
        else $error("digit changed without a latch");
    a_nop_unchanged: assert property (load_rise && (frm_addr == ADDR_NOP || frm_addr == ADDR_UNUSED)
        |=> $stable(decode_reg) && $stable(normal_reg) && $stable(test_reg) && $stable(scan_limit_reg)) // R20
        else $error("no-op frame changed a register");
    a_shutdown_entry: assert property (wr_shutdown && !frm_data[NORMAL_BIT] |=> !normal_reg ##1 pwr_reg == PWR_SHUTDOWN) // R9
        else $error("shutdown not entered");
    a_blank_output: assert property (!drive ##1 !drive |-> seg_reg == SEG_ALL_OFF && dig_reg == DIG_ALL_OFF) // R9
        else $error("display not blank in shutdown");
    a_test_override: assert property (test_reg ##1 test_reg |-> seg_reg == SEG_ALL_ON) // R13
        else $error("test did not override shutdown");
    a_wake_delay: assert property (pwr_reg == PWR_WAKING && pwr_next == PWR_ON |-> wake_cnt_reg == 32'(WAKE_COUNT - 1)) // R11
        else $error("wake delay wrong");
    a_reset_defaults: assert property ($past(soft_rst) |-> pwr_reg == PWR_SHUTDOWN && scan_limit_reg == RST_SCAN_LIMIT
        && decode_reg == RST_DECODE && intensity_reg == RST_INTENSITY) // R15
        else $error("defaults not restored");

    c_frame_latched: cover property (wr_digit);
    c_wake_done: cover property (pwr_reg == PWR_WAKING ##1 pwr_reg == PWR_ON);
    c_test_in_shutdown: cover property (test_reg && pwr_reg == PWR_SHUTDOWN);
endmodule : led_display_ctrl

// file: dv/host_link_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host end of the four-wire serial link
// ----------------------------------------
module host_link_model (
    input wire logic ser_dout,
    output logic ser_din,
    output logic ser_clk,
    output logic ser_load
);
    logic [15:0] echo; // Cascade bits seen during the last frame

    // Link clock stands low between frames
    initial begin
        ser_din = 1'b0;
        ser_clk = 1'b0;
        ser_load = 1'b0;
        echo = 16'h0000;
    end

    // One frame at 125 ns per bit; latch stays high until the next frame
    // Half-ns start offset keeps every pin change off the core clock edges
    task automatic send(input logic [15:0] frame);
        #62.5 ser_load = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            ser_din = frame[i];
            #31 ser_clk = 1'b1;
            #63 ser_clk = 1'b0;
            #31 echo = {echo[14:0], ser_dout};
        end
        ser_din = ~frame[0]; // No stale bit left on the line
        #31 ser_load = 1'b1;
    endtask : send
endmodule : host_link_model

// file: dv/serial_led_display_controller_tb.sv
`timescale 1ns/100ps
// ----------------------------------------
// Self-checking bench for the LED controller
// ----------------------------------------
module serial_led_display_controller_tb;
    import led_ctrl_pkg::*;
    localparam int LIMIT = 40000; // About three times the expected run
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ser_din, ser_clk, ser_load, ser_dout;
    logic [7:0] seg_out, digit_off;
    logic decode_now, ext_clk_sel, display_on;
    logic [3:0] intensity;
    logic [7:0] digit_exp [8]; // Expected digit memory
    logic [7:0] decode_exp = 8'h5A; // Expected decode selection
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;

    always #2 core_clk = ~core_clk;

    led_display_ctrl #(.WAKE_COUNT(20), .SCAN_COUNT(4)) dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .ser_din(ser_din), .ser_clk(ser_clk),
        .ser_load(ser_load), .ser_dout(ser_dout), .seg_out(seg_out), .digit_off(digit_off),
        .decode_now(decode_now), .intensity(intensity), .ext_clk_sel(ext_clk_sel),
        .display_on(display_on));
    host_link_model host_u (.ser_dout(ser_dout), .ser_din(ser_din), .ser_clk(ser_clk),
        .ser_load(ser_load));

    // ----------------------------------------
    // Compare and bus tasks
    // ----------------------------------------
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_cyc
    // Upper nibble always 4'hA, never zero, so it must be ignored
    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        @(negedge core_clk);
        host_u.send({4'hA, addr, data});
        wait_cyc(8); // Sync plus commit latency
    endtask : wr
    // Leave shutdown; display comes up only after the wake delay
    task automatic wake;
        wr(ADDR_SHUTDOWN_CONTROL, 8'h81);
        wait_cyc(12);
        chk_bit("waking", 1'b0, display_on);
        wait_cyc(10);
        chk_bit("awake", 1'b1, display_on);
    endtask : wake
    // Follow the scan through all eight digits
    task automatic show_digits;
        int k;
        for (int d = 0; d < 8; d++) begin
            k = 0;
            while (digit_off !== ~(8'h01 << d) && k < 200) begin
                @(negedge core_clk);
                k++;
            end
            chk_byte("scan", ~(8'h01 << d), digit_off);
            chk_byte("digit", digit_exp[d], seg_out);
            chk_bit("decode", decode_exp[d], decode_now);
        end
    endtask : show_digits

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk_byte("seg", SEG_ALL_OFF, seg_out);
        chk_byte("dig", DIG_ALL_OFF, digit_off);
        chk_bit("on", 1'b0, display_on);
        chk_byte("inten", 8'h00, {4'h0, intensity});
        chk_bit("dec", 1'b0, decode_now);
        chk_bit("ext", 1'b0, ext_clk_sel);
        $display("t_reset done");
    endtask : t_reset
    // Program digits, decode and scan limit while shut down, then wake
    task automatic t_program;
        for (int d = 0; d < 8; d++) begin
            digit_exp[d] = 8'(8'h1F + d * 8'h23);
            wr(ADDR_DIGIT0 + 4'(d), digit_exp[d]);
        end
        wr(ADDR_DECODE, decode_exp);
        wr(ADDR_SCAN_LIMIT, 8'hF7);
        chk_byte("seg", SEG_ALL_OFF, seg_out);
        wake;
        show_digits;
        $display("t_program done");
    endtask : t_program
    // Enter shutdown, write there, leave again (a flash cycle)
    task automatic t_shutdown;
        wr(ADDR_SHUTDOWN_CONTROL, 8'hFE);
        wr(ADDR_INTENSITY, 8'h03);
        digit_exp[3] = 8'hC3;
        wr(ADDR_DIGIT0 + 4'h3, digit_exp[3]);
        chk_byte("seg", SEG_ALL_OFF, seg_out);
        chk_byte("dig", DIG_ALL_OFF, digit_off);
        chk_bit("on", 1'b0, display_on);
        chk_byte("inten", 8'h03, {4'h0, intensity});
        wake;
        show_digits;
        $display("t_shutdown done");
    endtask : t_shutdown
    // Display test lights everything even when shut down
    task automatic t_test;
        wr(ADDR_SHUTDOWN_CONTROL, 8'h00);
        wr(ADDR_TEST, 8'h01);
        chk_byte("seg", SEG_ALL_ON, seg_out);
        chk_bit("lit", 1'b0, &digit_off);
        wr(ADDR_TEST, 8'h00);
        chk_byte("seg", SEG_ALL_OFF, seg_out);
        wake;
        $display("t_test done");
    endtask : t_test
    // No-op and unused frames; cascade echoes the frame before
    task automatic t_nop;
        wr(ADDR_NOP, 8'hAA);
        wr(ADDR_UNUSED, 8'hBB);
        show_digits;
        wr(ADDR_NOP, 8'h5C);
        chk_byte("dout hi", 8'hAD, host_u.echo[15:8]);
        chk_byte("dout lo", 8'hBB, host_u.echo[7:0]);
        $display("t_nop done");
    endtask : t_nop
    // Intensity, clock select and software reset
    task automatic t_ctrl;
        wr(ADDR_INTENSITY, 8'hF9);
        chk_byte("inten", 8'h09, {4'h0, intensity});
        wr(ADDR_RESET_CLOCK, 8'h01);
        chk_bit("ext", 1'b1, ext_clk_sel);
        wr(ADDR_RESET_CLOCK, 8'h03);
        chk_byte("inten", 8'h00, {4'h0, intensity});
        chk_bit("on", 1'b0, display_on);
        chk_byte("seg", SEG_ALL_OFF, seg_out);
        // After the reset only digit 0 scans, cleared and undecoded
        wake;
        chk_byte("one digit", 8'hFE, digit_off);
        chk_byte("digit cleared", RST_DIGIT, seg_out);
        chk_bit("dec off", 1'b0, decode_now);
        chk_bit("ext kept", 1'b1, ext_clk_sel);
        $display("t_ctrl done");
    endtask : t_ctrl

    // ----------------------------------------
    // Verdict, sequence and hang guard
    // ----------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    initial begin
        wait_cyc(10);
        sys_rst = 1'b0;
        wait_cyc(3); // Flush the pin synchronisers
        t_reset;
        t_program;
        t_shutdown;
        t_test;
        t_nop;
        t_ctrl;
        summarize;
    end

    // Cut a hang short
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            summarize;
        end
    end
endmodule : serial_led_display_controller_tb
